/* src/sppl_top.sv */
// Shared port pin logic: four ports, segment sharing, edge events, APB registers
`timescale 1ns/1ps

module sppl_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port_eight_pins_in,
   output logic      [7:0]  port_eight_pins_out,
   output logic      [7:0]  port_eight_pins_oe,
   output logic      [7:0]  port_eight_pull_en,
   input  wire logic [7:0]  port_nine_pins_in,
   output logic      [7:0]  port_nine_pins_out,
   output logic      [7:0]  port_nine_pins_oe,
   output logic      [7:0]  port_nine_pull_en,
   input  wire logic [3:0]  port_ten_pins_in,
   output logic      [3:0]  port_ten_pins_out,
   output logic      [3:0]  port_ten_pins_oe,
   output logic      [3:0]  port_ten_pull_en,
   input  wire logic [7:0]  port_eleven_pins_in,
   output logic      [7:0]  port_eleven_pins_out,
   output logic      [7:0]  port_eleven_pins_oe,
   output logic      [7:0]  port_eleven_pull_en,
   input  wire logic [7:0]  segment_outputs_high_shared,
   input  wire logic [7:0]  segment_outputs_low_shared,
   input  wire logic [5:0]  external_irq_input,
   output logic             irq
);

   // ****************************************
   // Software registers
   // ****************************************
   logic [7:0]  latch8;
   logic [7:0]  dir8;
   logic [7:0]  pull8;
   logic [7:0]  latch9;
   logic [7:0]  dir9;
   logic [7:0]  pull9;
   logic [3:0]  latch10;
   logic [3:0]  dir10;
   logic [3:0]  pull10;
   logic [7:0]  latch11;
   logic [7:0]  dir11;
   logic [7:0]  pull11;
   logic [7:0]  lcd_display_control;
   logic [11:0] edge_sel;
   logic [13:0] irq_status;
   logic [13:0] irq_mask;
   logic [13:0] stat_snap;
   logic [13:0] next_irq_status;

   // ****************************************
   // Pin samplers
   // ****************************************
   sppl_edge_if #(.W(8)) s8 ();
   sppl_edge_if #(.W(8)) s9 ();
   sppl_edge_if #(.W(4)) s10 ();
   sppl_edge_if #(.W(8)) s11 ();
   sppl_edge_if #(.W(6)) sx ();

   sppl_edge #(.W(8)) u_s8  (.pclk(pclk), .presetn(presetn), .bus(s8.edge_side));
   sppl_edge #(.W(8)) u_s9  (.pclk(pclk), .presetn(presetn), .bus(s9.edge_side));
   sppl_edge #(.W(4)) u_s10 (.pclk(pclk), .presetn(presetn), .bus(s10.edge_side));
   sppl_edge #(.W(8)) u_s11 (.pclk(pclk), .presetn(presetn), .bus(s11.edge_side));
   sppl_edge #(.W(6)) u_sx  (.pclk(pclk), .presetn(presetn), .bus(sx.edge_side));

   // Plain ports sample levels only
   assign s8.raw      = port_eight_pins_in;
   assign s8.rise_en  = '0;
   assign s8.fall_en  = '0;
   assign s9.raw      = port_nine_pins_in;
   assign s9.rise_en  = '0;
   assign s9.fall_en  = '0;
   assign s10.raw     = port_ten_pins_in;
   assign s10.rise_en = '0;
   assign s10.fall_en = '0;

   // Port eleven watches falling edges on every pin
   assign s11.raw     = port_eleven_pins_in;
   assign s11.rise_en = '0;
   assign s11.fall_en = 8'hff;

   // External inputs take their edge choice from software
   assign sx.raw = external_irq_input;
   genvar gi;
   generate
      for (gi = 0; gi < sppl_pkg::EXT_N; gi++) begin : g_sel
         assign sx.rise_en[gi] = edge_sel[2*gi];
         assign sx.fall_en[gi] = edge_sel[2*gi+1];
      end
   endgenerate

   // ****************************************
   // Segment sharing
   // ****************************************
   logic [7:0] seg8;
   logic [7:0] seg9;
   logic [7:0] segdat8;
   logic [7:0] segdat9;

   // One control bit covers two neighbouring pins
   generate
      for (gi = 0; gi < sppl_pkg::PAIR_N; gi++) begin : g_pair
         assign seg8[2*gi+1 -: 2] = {2{lcd_display_control[sppl_pkg::LCD_P8_LSB+gi]}};
         assign seg9[2*gi+1 -: 2] = {2{lcd_display_control[sppl_pkg::LCD_P9_LSB+gi]}};
      end
   endgenerate

   // Segment numbering runs opposite to pin numbering
   assign segdat8 = {<<{segment_outputs_high_shared}};
   assign segdat9 = {<<{segment_outputs_low_shared}};

   // ****************************************
   // APB decode
   // ****************************************
   logic access;
   logic take;
   logic fire;
   logic wr;
   logic hit_any;
   logic [31:0] rd_value;

   assign access = psel & penable;
   assign take   = access & ~pready;
   assign fire   = access & pready;
   assign wr     = fire & pwrite;

   logic a_l8, a_d8, a_p8, a_l9, a_d9, a_p9, a_l10, a_d10, a_p10;
   logic a_l11, a_d11, a_p11, a_lcd, a_i8, a_i9, a_i10, a_i11;
   logic a_es, a_st, a_mk;

   assign a_l8  = paddr == sppl_pkg::P8_LATCH;
   assign a_d8  = paddr == sppl_pkg::P8_DIR;
   assign a_p8  = paddr == sppl_pkg::P8_PULL;
   assign a_l9  = paddr == sppl_pkg::P9_LATCH;
   assign a_d9  = paddr == sppl_pkg::P9_DIR;
   assign a_p9  = paddr == sppl_pkg::P9_PULL;
   assign a_l10 = paddr == sppl_pkg::P10_LATCH;
   assign a_d10 = paddr == sppl_pkg::P10_DIR;
   assign a_p10 = paddr == sppl_pkg::P10_PULL;
   assign a_l11 = paddr == sppl_pkg::P11_LATCH;
   assign a_d11 = paddr == sppl_pkg::P11_DIR;
   assign a_p11 = paddr == sppl_pkg::P11_PULL;
   assign a_lcd = paddr == sppl_pkg::LCD_CTRL;
   assign a_i8  = paddr == sppl_pkg::P8_PINS;
   assign a_i9  = paddr == sppl_pkg::P9_PINS;
   assign a_i10 = paddr == sppl_pkg::P10_PINS;
   assign a_i11 = paddr == sppl_pkg::P11_PINS;
   assign a_es  = paddr == sppl_pkg::EDGE_SEL;
   assign a_st  = paddr == sppl_pkg::IRQ_STAT;
   assign a_mk  = paddr == sppl_pkg::IRQ_MASK;

   assign hit_any = a_l8 | a_d8 | a_p8 | a_l9 | a_d9 | a_p9 | a_l10 | a_d10 | a_p10
                  | a_l11 | a_d11 | a_p11 | a_lcd | a_i8 | a_i9 | a_i10 | a_i11
                  | a_es | a_st | a_mk;

   // Read selection, narrow fields in the low bits
   assign rd_value = a_l8  ? {24'h00_0000, latch8} :
                     a_d8  ? {24'h00_0000, dir8} :
                     a_p8  ? {24'h00_0000, pull8} :
                     a_l9  ? {24'h00_0000, latch9} :
                     a_d9  ? {24'h00_0000, dir9} :
                     a_p9  ? {24'h00_0000, pull9} :
                     a_l10 ? {28'h000_0000, latch10} :
                     a_d10 ? {28'h000_0000, dir10} :
                     a_p10 ? {28'h000_0000, pull10} :
                     a_l11 ? {24'h00_0000, latch11} :
                     a_d11 ? {24'h00_0000, dir11} :
                     a_p11 ? {24'h00_0000, pull11} :
                     a_lcd ? {24'h00_0000, lcd_display_control} :
                     a_i8  ? {24'h00_0000, s8.level} :
                     a_i9  ? {24'h00_0000, s9.level} :
                     a_i10 ? {28'h000_0000, s10.level} :
                     a_i11 ? {24'h00_0000, s11.level} :
                     a_es  ? {20'h0_0000, edge_sel} :
                     a_st  ? {18'h0_0000, irq_status} :
                     a_mk  ? {18'h0_0000, irq_mask} :
                     sppl_pkg::DATA_RST;

   // ****************************************
   // APB answer: one wait cycle, registered
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= sppl_pkg::DATA_RST;
      end else begin
         pready  <= take;
         pslverr <= take & ~hit_any;
         if (take && !pwrite) begin
            prdata <= rd_value;
         end
      end
   end

   // ****************************************
   // Port eight and nine registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch8 <= sppl_pkg::WIDE_RST;
         dir8   <= sppl_pkg::WIDE_RST;
         pull8  <= sppl_pkg::WIDE_RST;
         latch9 <= sppl_pkg::WIDE_RST;
         dir9   <= sppl_pkg::WIDE_RST;
         pull9  <= sppl_pkg::WIDE_RST;
      end else begin
         if (wr && a_l8) latch8 <= pwdata[7:0];
         if (wr && a_d8) dir8 <= pwdata[7:0];
         if (wr && a_p8) pull8 <= pwdata[7:0];
         if (wr && a_l9) latch9 <= pwdata[7:0];
         if (wr && a_d9) dir9 <= pwdata[7:0];
         if (wr && a_p9) pull9 <= pwdata[7:0];
      end
   end

   // ****************************************
   // Port ten and eleven registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch10 <= sppl_pkg::NARROW_RST;
         dir10   <= sppl_pkg::NARROW_RST;
         pull10  <= sppl_pkg::NARROW_RST;
         latch11 <= sppl_pkg::WIDE_RST;
         dir11   <= sppl_pkg::WIDE_RST;
         pull11  <= sppl_pkg::WIDE_RST;
      end else begin
         if (wr && a_l10) latch10 <= pwdata[3:0];
         if (wr && a_d10) dir10 <= pwdata[3:0];
         if (wr && a_p10) pull10 <= pwdata[3:0];
         if (wr && a_l11) latch11 <= pwdata[7:0];
         if (wr && a_d11) dir11 <= pwdata[7:0];
         if (wr && a_p11) pull11 <= pwdata[7:0];
      end
   end

   // ****************************************
   // Display control, edge select, mask
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_display_control <= sppl_pkg::LCD_RST;
         edge_sel            <= sppl_pkg::EDGE_SEL_RST;
         irq_mask            <= sppl_pkg::IRQ_RST;
      end else begin
         if (wr && a_lcd) lcd_display_control <= pwdata[7:0];
         if (wr && a_es) edge_sel <= pwdata[11:0];
         if (wr && a_mk) irq_mask <= pwdata[13:0];
      end
   end

   // ****************************************
   // Event status and interrupt
   // ****************************************
   logic [13:0] events;
   logic [13:0] clr;

   // Only bits that software actually saw are cleared; new hits win
   assign events = {s11.hit, sx.hit};
   assign clr    = (fire && !pwrite && a_st) ? stat_snap : sppl_pkg::IRQ_RST;
   assign next_irq_status = (irq_status & ~clr) | events;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= sppl_pkg::IRQ_RST;
         stat_snap  <= sppl_pkg::IRQ_RST;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (take) stat_snap <= irq_status;
         irq <= |(next_irq_status & irq_mask);
      end
   end

   // ****************************************
   // Pin drivers, all registered
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_eight_pins_out  <= sppl_pkg::WIDE_RST;
         port_eight_pins_oe   <= sppl_pkg::WIDE_RST;
         port_eight_pull_en   <= sppl_pkg::WIDE_RST;
         port_nine_pins_out   <= sppl_pkg::WIDE_RST;
         port_nine_pins_oe    <= sppl_pkg::WIDE_RST;
         port_nine_pull_en    <= sppl_pkg::WIDE_RST;
      end else begin
         port_eight_pins_out <= (seg8 & segdat8) | (~seg8 & latch8);
         port_eight_pins_oe  <= seg8 | dir8;
         port_eight_pull_en  <= pull8 & ~dir8 & ~seg8;
         port_nine_pins_out  <= (seg9 & segdat9) | (~seg9 & latch9);
         port_nine_pins_oe   <= seg9 | dir9;
         port_nine_pull_en   <= pull9 & ~dir9 & ~seg9;
      end
   end

   // Ports without segment sharing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_ten_pins_out    <= sppl_pkg::NARROW_RST;
         port_ten_pins_oe     <= sppl_pkg::NARROW_RST;
         port_ten_pull_en     <= sppl_pkg::NARROW_RST;
         port_eleven_pins_out <= sppl_pkg::WIDE_RST;
         port_eleven_pins_oe  <= sppl_pkg::WIDE_RST;
         port_eleven_pull_en  <= sppl_pkg::WIDE_RST;
      end else begin
         port_ten_pins_out    <= latch10;
         port_ten_pins_oe     <= dir10;
         port_ten_pull_en     <= pull10 & ~dir10;
         port_eleven_pins_out <= latch11;
         port_eleven_pins_oe  <= dir11;
         port_eleven_pull_en  <= pull11 & ~dir11;
      end
   end

endmodule

/* src/sppl_pkg.sv */
// Shared port pin logic: register map, field layout and reset values
package sppl_pkg;

   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] P8_LATCH  = 8'h00;
   localparam logic [7:0] P8_DIR    = 8'h04;
   localparam logic [7:0] P8_PULL   = 8'h08;
   localparam logic [7:0] P9_LATCH  = 8'h0c;
   localparam logic [7:0] P9_DIR    = 8'h10;
   localparam logic [7:0] P9_PULL   = 8'h14;
   localparam logic [7:0] P10_LATCH = 8'h18;
   localparam logic [7:0] P10_DIR   = 8'h1c;
   localparam logic [7:0] P10_PULL  = 8'h20;
   localparam logic [7:0] P11_LATCH = 8'h24;
   localparam logic [7:0] P11_DIR   = 8'h28;
   localparam logic [7:0] P11_PULL  = 8'h2c;
   localparam logic [7:0] LCD_CTRL  = 8'h30;
   localparam logic [7:0] P8_PINS   = 8'h34;
   localparam logic [7:0] P9_PINS   = 8'h38;
   localparam logic [7:0] P10_PINS  = 8'h3c;
   localparam logic [7:0] P11_PINS  = 8'h40;
   localparam logic [7:0] EDGE_SEL  = 8'h44;
   localparam logic [7:0] IRQ_STAT  = 8'h48;
   localparam logic [7:0] IRQ_MASK  = 8'h4c;

   // ****************************************
   // Field widths and positions
   // ****************************************
   localparam int WIDE_W       = 8;
   localparam int NARROW_W     = 4;
   localparam int PAIR_N       = 4;
   localparam int LCD_P8_LSB   = 0;
   localparam int LCD_P9_LSB   = 4;
   localparam int LCD_W        = 8;
   localparam int EXT_N        = 6;
   localparam int EDGE_SEL_W   = 12;
   localparam int IRQ_EXT_LSB  = 0;
   localparam int IRQ_FALL_LSB = 6;
   localparam int IRQ_W        = 14;

   // ****************************************
   // Edge select codes, two bits per input
   // ****************************************
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0]  WIDE_RST     = 8'h00;
   localparam logic [3:0]  NARROW_RST   = 4'h0;
   localparam logic [7:0]  LCD_RST      = 8'h00;
   localparam logic [11:0] EDGE_SEL_RST = 12'h000;
   localparam logic [13:0] IRQ_RST      = 14'h0000;
   localparam logic [31:0] DATA_RST     = 32'h0000_0000;

endpackage

/* src/sppl_edge_if.sv */
// Interface between the register block and one pin sampler
`timescale 1ns/1ps
interface sppl_edge_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] rise_en;
   logic [W-1:0] fall_en;
   logic [W-1:0] level;
   logic [W-1:0] hit;

   modport edge_side (input raw, input rise_en, input fall_en, output level, output hit);
   modport user (output raw, output rise_en, output fall_en, input level, input hit);
endinterface

/* src/sppl_edge.sv */
// Pin sampler: two-stage synchroniser with selectable edge detection
`timescale 1ns/1ps
module sppl_edge #(
   parameter int W = 8
) (
   input  wire logic  pclk,
   input  wire logic  presetn,
   sppl_edge_if.edge_side bus
);

   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic [W-1:0] prev;

   // ****************************************
   // Synchroniser and history
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else begin
         meta <= bus.raw;
         sync <= meta;
         prev <= sync;
      end
   end

   // Level and one-cycle edge hits
   assign bus.level = sync;
   assign bus.hit   = (bus.rise_en & sync & ~prev) | (bus.fall_en & ~sync & prev);

endmodule

/* dv/sppl_monitor.sv */
// Port assertions for the shared port pin logic
`timescale 1ns/1ps
module sppl_monitor (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic       pready,
   input wire logic [7:0] port_eight_pins_out,
   input wire logic [7:0] port_eight_pins_oe,
   input wire logic [7:0] port_eight_pull_en,
   input wire logic [7:0] port_nine_pins_oe,
   input wire logic [7:0] port_nine_pull_en,
   input wire logic [3:0] port_ten_pins_oe,
   input wire logic [3:0] port_ten_pull_en,
   input wire logic [7:0] port_eleven_pins_oe,
   input wire logic [7:0] port_eleven_pull_en,
   input wire logic [7:0] port_eleven_pins_in,
   input wire logic [7:0] segment_outputs_high_shared,
   input wire logic [5:0] external_irq_input,
   input wire logic       irq
);
   logic [3:0] wr_h;
   logic [3:0] acc_h;
   logic [7:0] ev_h;
   logic [3:0] sg_h;

   // Recent causes: writes, accesses, pin and segment changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_h  <= 4'h0;
         acc_h <= 4'h0;
         ev_h  <= 8'h00;
         sg_h  <= 4'h0;
      end else begin
         wr_h  <= {wr_h[2:0], psel & penable & pready & pwrite};
         acc_h <= {acc_h[2:0], psel & penable & pready};
         ev_h  <= {ev_h[6:0], $changed(external_irq_input) | $changed(port_eleven_pins_in)};
         sg_h  <= {sg_h[2:0], $changed(segment_outputs_high_shared)};
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_end;
      psel && penable && pready;
   endsequence
   sequence s_quiet;
      !pready && !irq && port_eight_pins_oe == 8'h00 && port_nine_pins_oe == 8'h00
      && port_ten_pins_oe == 4'h0 && port_eleven_pins_oe == 8'h00
      && port_eight_pull_en == 8'h00 && port_eleven_pull_en == 8'h00;
   endsequence

   chk_reset_quiet: assert property ($rose(presetn) |-> s_quiet)
      else $error("outputs not idle after reset");
   chk_pull_input_only: assert property ((port_eight_pull_en & port_eight_pins_oe) == 8'h00
      && (port_nine_pull_en & port_nine_pins_oe) == 8'h00
      && (port_eleven_pull_en & port_eleven_pins_oe) == 8'h00)
      else $error("pull-up on a driven pin");
   chk_ten_pull_only: assert property ((port_ten_pull_en & port_ten_pins_oe) == 4'h0)
      else $error("pull-up on a driven port ten pin");
   chk_eight_dir_cause: assert property ($changed(port_eight_pins_oe) |-> wr_h != 4'h0)
      else $error("port eight direction changed without a write");
   chk_nine_dir_cause: assert property ($changed(port_nine_pins_oe) |-> wr_h != 4'h0)
      else $error("port nine direction changed without a write");
   chk_eleven_dir_cause: assert property ($changed(port_eleven_pins_oe) |-> wr_h != 4'h0)
      else $error("port eleven direction changed without a write");
   chk_seg_out_cause: assert property ($changed(port_eight_pins_out) |-> (wr_h | sg_h) != 4'h0)
      else $error("port eight level changed without cause");
   chk_irq_rise_cause: assert property ($rose(irq) |-> ev_h != 8'h00 || wr_h != 4'h0)
      else $error("interrupt rose without an event");
   chk_irq_fall_cause: assert property ($fell(irq) |-> acc_h != 4'h0)
      else $error("interrupt fell without an access");
   chk_ready_one_cycle: assert property (s_end |=> !pready)
      else $error("ready held longer than one cycle");
endmodule

/* dv/sppl_pins_model.sv */
// Outside circuitry on one port: driver, pull-up and floating wire
`timescale 1ns/1ps
module sppl_pins_model #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] pclk,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pull,
   input  wire logic [W-1:0] drv,
   input  wire logic [W-1:0] drv_en,
   output logic      [W-1:0] level
);
   logic [W-1:0] last = '0;

   // Own drive wins, then outside driver, then pull-up, else floating
   always_comb begin
      for (int k = 0; k < W; k++) begin
         if (oe[k])
            level[k] = out[k];
         else if (drv_en[k])
            level[k] = drv[k];
         else if (pull[k])
            level[k] = 1'b1;
         else
            level[k] = ~last[k];
      end
   end

   // Floating wire flips every cycle
   always_ff @(posedge pclk[0]) last <= level;
endmodule

/* dv/sppl_top_bench.sv */
// Self-checking bench for the shared port pin logic
`timescale 1ns/1ps
module sppl_top_bench;
   localparam logic [32:0] ALL = 33'h1_ffff_ffff;
   localparam logic [7:0] WM [4] = '{8'hff, 8'hff, 8'h0f, 8'hff};
   localparam logic [7:0] LAT [4] = '{sppl_pkg::P8_LATCH, sppl_pkg::P9_LATCH,
                                      sppl_pkg::P10_LATCH, sppl_pkg::P11_LATCH};
   localparam logic [7:0] DIR [4] = '{sppl_pkg::P8_DIR, sppl_pkg::P9_DIR,
                                      sppl_pkg::P10_DIR, sppl_pkg::P11_DIR};
   localparam logic [7:0] PUL [4] = '{sppl_pkg::P8_PULL, sppl_pkg::P9_PULL,
                                      sppl_pkg::P10_PULL, sppl_pkg::P11_PULL};
   localparam logic [7:0] PIN [4] = '{sppl_pkg::P8_PINS, sppl_pkg::P9_PINS,
                                      sppl_pkg::P10_PINS, sppl_pkg::P11_PINS};
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [7:0]  seg_hi = 8'h00;
   logic [7:0]  seg_lo = 8'h00;
   logic [5:0]  ext = 6'h00;
   logic [7:0]  po [4];
   logic [7:0]  pe [4];
   logic [7:0]  pp [4];
   logic [7:0]  pi [4];
   logic [7:0]  drv [4] = '{default: 8'h00};
   logic [7:0]  den [4] = '{default: 8'hff};
   logic [7:0]  dvs [4];
   logic [7:0]  pvs [4];
   logic [32:0] exp_q [$];
   logic [32:0] care_q [$];
   logic [32:0] ex;
   logic [32:0] cr;
   integer      seed = 32'hc4e3;
   int          num_errors = 0;
   int          check_count = 0;
   int          cycles = 0;

   always #5 pclk = ~pclk;

   sppl_top i_sppl_top (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .port_eight_pins_in(pi[0]), .port_eight_pins_out(po[0]),
      .port_eight_pins_oe(pe[0]), .port_eight_pull_en(pp[0]),
      .port_nine_pins_in(pi[1]), .port_nine_pins_out(po[1]),
      .port_nine_pins_oe(pe[1]), .port_nine_pull_en(pp[1]),
      .port_ten_pins_in(pi[2][3:0]), .port_ten_pins_out(po[2][3:0]),
      .port_ten_pins_oe(pe[2][3:0]), .port_ten_pull_en(pp[2][3:0]),
      .port_eleven_pins_in(pi[3]), .port_eleven_pins_out(po[3]),
      .port_eleven_pins_oe(pe[3]), .port_eleven_pull_en(pp[3]),
      .segment_outputs_high_shared(seg_hi), .segment_outputs_low_shared(seg_lo),
      .external_irq_input(ext), .irq);

   // Outside circuitry on each port
   for (genvar g = 0; g < 4; g++) begin : g_pin
      sppl_pins_model i_sppl_pins_model (.pclk({8{pclk}}), .out(po[g]), .oe(pe[g]),
         .pull(pp[g]), .drv(drv[g]), .drv_en(den[g]), .level(pi[g]));
   end

   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] e);
      check_count++;
      if (seen !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One bus transfer; the expected answer is noted first
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e, input logic [32:0] c);
      exp_q.push_back(e);
      care_q.push_back(c);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0_0000_0000, 33'h1_0000_0000);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] c);
      apb(1'b0, a, 32'h0000_0000, e, c);
   endtask

   // Compare each completed access with the oldest note
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 8000) begin
         num_errors++;
         print_verdict();
      end
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         ex = exp_q.pop_front();
         cr = care_q.pop_front();
         check("bus", {pslverr, prdata} & cr, ex & cr);
      end
   end

   initial begin
      logic [7:0]  dv, lv, pv, dr, sm, sv, fv;
      logic [1:0]  ec;
      logic [31:0] be;
      tick(8);
      presetn <= 1'b1;
      tick(1);
      for (int g = 0; g < 4; g++) begin
         check("oe", 33'(pe[g] & WM[g]), 33'h0);
         check("pull", 33'(pp[g] & WM[g]), 33'h0);
         rd(DIR[g], 33'h0, ALL);
         rd(PUL[g], 33'h0, ALL);
      end
      rd(sppl_pkg::LCD_CTRL, 33'h0, ALL);
      rd(8'h50, 33'h1_0000_0000, ALL);
      $display("reset test done");
      // No conversion runs, so latch rewrites are free
      for (int g = 0; g < 4; g++) begin
         dv = 8'($random(seed)) & WM[g];
         lv = 8'($random(seed)) & WM[g];
         pv = 8'($random(seed)) & WM[g];
         dr = 8'($random(seed));
         dvs[g] = dv;
         pvs[g] = pv;
         den[g] <= ~pv;
         drv[g] <= dr;
         wr(LAT[g], 32'(lv));
         wr(DIR[g], 32'(dv));
         wr(PUL[g], 32'(pv));
         tick(4);
         check("oe", 33'(pe[g] & WM[g]), 33'(dv));
         check("out", 33'(po[g] & dv), 33'(lv & dv));
         check("pull", 33'(pp[g] & WM[g]), 33'(pv & ~dv));
         rd(DIR[g], 33'(dv), ALL);
         rd(PIN[g], 33'((dv & lv) | (~dv & pv) | (~dv & ~pv & dr & WM[g])), ALL);
      end
      $display("direction test done");
      for (int i = 0; i < 16; i++) begin
         wr(sppl_pkg::LCD_CTRL, 32'({4'(i), 4'(15 - i)}));
         seg_hi <= 8'($random(seed));
         seg_lo <= 8'($random(seed));
         tick(2);
         for (int g = 0; g < 2; g++) begin
            sm = {{2{1'b0}}, 6'h00} | (g ? {{2{i[3]}}, {2{i[2]}}, {2{i[1]}}, {2{i[0]}}}
                                         : ~{{2{i[3]}}, {2{i[2]}}, {2{i[1]}}, {2{i[0]}}});
            sv = g ? seg_lo : seg_hi;
            sv = {<<{sv}};
            check("seg_oe", 33'(pe[g]), 33'(dvs[g] | sm));
            check("seg_out", 33'(po[g] & sm), 33'(sv & sm));
            check("seg_pull", 33'(pp[g]), 33'(pvs[g] & ~dvs[g] & ~sm));
         end
      end
      wr(sppl_pkg::LCD_CTRL, 32'h0000_0000);
      $display("segment test done");
      wr(sppl_pkg::IRQ_MASK, 32'h0000_3fff);
      rd(sppl_pkg::IRQ_STAT, 33'h0, 33'h0);
      for (int i = 0; i < 6; i++) begin
         for (int c = 0; c < 4; c++) begin
            ec = 2'(c);
            wr(sppl_pkg::EDGE_SEL, 32'(ec) << (2 * i));
            for (int r = 1; r >= 0; r--) begin
               ext[i] <= 1'(r);
               tick(6);
               be = (ec == (r ? sppl_pkg::EDGE_RISE : sppl_pkg::EDGE_FALL)
                     || ec == sppl_pkg::EDGE_BOTH) ? 32'h0000_0001 << i : 32'h0000_0000;
               check("irq", 33'(irq), 33'(be != 32'h0000_0000));
               rd(sppl_pkg::IRQ_STAT, 33'(be), ALL);
            end
         end
      end
      $display("edge test done");
      den[3] <= 8'hff;
      drv[3] <= 8'hff;
      wr(PUL[3], 32'h0000_0000);
      wr(DIR[3], 32'h0000_0000);
      tick(6);
      wr(sppl_pkg::IRQ_MASK, 32'h0000_0000);
      rd(sppl_pkg::IRQ_STAT, 33'h0, 33'h0);
      fv = 8'($random(seed)) | 8'h01;
      drv[3] <= ~fv;
      tick(6);
      check("irq", 33'(irq), 33'h0);
      wr(sppl_pkg::IRQ_MASK, 32'h0000_3fc0);
      tick(2);
      check("irq", 33'(irq), 33'h1);
      rd(sppl_pkg::IRQ_STAT, 33'({fv, 6'h00}), ALL);
      tick(2);
      check("irq", 33'(irq), 33'h0);
      $display("falling test done");
      print_verdict();
   end
endmodule

bind sppl_top sppl_monitor i_sppl_monitor (
   .pclk, .presetn, .psel, .penable, .pwrite, .pready, .port_eight_pins_out,
   .port_eight_pins_oe, .port_eight_pull_en, .port_nine_pins_oe, .port_nine_pull_en,
   .port_ten_pins_oe, .port_ten_pull_en, .port_eleven_pins_oe, .port_eleven_pull_en,
   .port_eleven_pins_in, .segment_outputs_high_shared, .external_irq_input, .irq);
